// ===== src/csb_pkg.sv
package csb_pkg;
    // oscillator select encodings
    localparam logic [1:0] OSC_CRYSTAL  = 2'h0;
    localparam logic [1:0] OSC_INT_RC   = 2'h1;
    localparam logic [1:0] OSC_RESERVED = 2'h2;
    localparam logic [1:0] OSC_EXT_CLK  = 2'h3;
    // configuration byte addresses
    localparam logic [15:0] CFG0_ADDR = 16'hfb00;
    localparam logic [15:0] CFG1_ADDR = 16'hfb01;
    // field positions in configuration byte zero
    localparam int CFG0_WDOG_BIT  = 7;
    localparam int CFG0_BOV_HI    = 6;
    localparam int CFG0_BOV_LO    = 5;
    localparam int CFG0_FILT_BIT  = 2;
    localparam int CFG0_OSC_HI    = 1;
    localparam int CFG0_OSC_LO    = 0;
    // field positions in configuration byte one
    localparam int CFG1_RCF_BIT   = 5;
    // auxiliary clock control
    localparam int ACK_CLKOUT_BIT = 7;
    // brownout encodings of the configuration field (trip in centivolts)
    localparam logic [1:0] CFG_BROWNOUT_LEVEL_2V4 = 2'h3;
    localparam logic [1:0] CFG_BROWNOUT_LEVEL_2V7 = 2'h2;
    localparam logic [1:0] CFG_BROWNOUT_LEVEL_3V8 = 2'h1;
    localparam logic [1:0] CFG_BROWNOUT_LEVEL_4V5 = 2'h0;
    localparam logic [8:0] TRIP_2V4 = 9'h0f0;
    localparam logic [8:0] TRIP_2V7 = 9'h10e;
    localparam logic [8:0] TRIP_3V8 = 9'h17c;
    localparam logic [8:0] TRIP_4V5 = 9'h1c2;
    // reset values
    localparam logic [7:0] CFG_RST = 8'hff;
    // clock output divider: toggle every 2 cycles gives 1/4 rate
    localparam int CLKOUT_DIV  = 4;
    localparam int CLKOUT_HALF = CLKOUT_DIV / 2;
    // low-power brownout duty cycle in detector clock periods
    localparam int LP_SENSE_PER = 64;
    localparam int LP_OFF_PER   = 960;
    // brownout response states
    typedef enum logic [2:0] {
        BO_OK   = 3'b001,
        BO_LOW  = 3'b010,
        BO_IDLE = 3'b100
    } csb_bo_type;
endpackage

// ===== src/csb_duty_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the top and the low-power duty sequencer
interface csb_duty_if;
    logic run;      // request duty cycling
    logic tick;     // detector clock enable
    logic sense;    // detector powered
    modport ctrl (output run, output tick, input sense);
    modport seq  (input run, input tick, output sense);
endinterface
`default_nettype wire

// ===== src/csb_duty_seq.sv
`timescale 1ns/1ps
`default_nettype none
module csb_duty_seq (
    input  wire logic    mclk,   // system clock
    input  wire logic    srst,   // sync reset
    csb_duty_if.seq      duty    // duty control
);
    import csb_pkg::*;

    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic       on_q;
    logic       on_d;

    // sense for 64 ticks, off for 960, repeat while requested
    always_comb begin
        cnt_d = cnt_q;
        on_d  = on_q;
        if (!duty.run) begin
            cnt_d = 10'h000;
            on_d  = 1'b1;
        end else if (duty.tick) begin
            if (on_q && cnt_q == 10'(LP_SENSE_PER - 1)) begin
                cnt_d = 10'h000;
                on_d  = 1'b0;
            end else if (!on_q && cnt_q == 10'(LP_OFF_PER - 1)) begin
                cnt_d = 10'h000;
                on_d  = 1'b1;
            end else begin
                cnt_d = cnt_q + 10'h001;
            end
        end
    end

    // state registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= 10'h000;
            on_q  <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            on_q  <= on_d;
        end
    end

    assign duty.sense = on_q;

    chk_sense_len: assert property (
        @(posedge mclk) disable iff (srst)
        duty.run && on_q && duty.tick && cnt_q == 10'h03f
        |=> !on_q) else $error("sense phase not 64 ticks");
    chk_off_len: assert property (
        @(posedge mclk) disable iff (srst)
        duty.run && !on_q && duty.tick && cnt_q == 10'h3bf
        |=> on_q) else $error("off phase not 960 ticks");
endmodule
`default_nettype wire

// ===== src/csb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csb_top (
    input  wire logic       mclk,              // cpu clock
    input  wire logic       srst,              // sync reset, power-on
    input  wire logic       cfg_load,          // pulse: flash bytes valid
    input  wire logic [7:0] cfg_byte_zero,     // flash byte at fb00
    input  wire logic [7:0] cfg_byte_one,      // flash byte at fb01
    input  wire logic [7:0] aux_clock_ctrl,    // auxiliary clock control
    input  wire logic [1:0] brownout_level_wr, // software level value
    input  wire logic       brownout_level_we, // pulse: level write
    input  wire logic       bo_reset_en,       // 1 reset, 0 interrupt
    input  wire logic       low_power_brownout,// duty-cycled sensing while in BO_LOW
    input  wire logic       detector_rc_tick,  // detector clock enable
    input  wire logic       vdd_below,         // comparator: below trip
    input  wire logic       port_out_bit,      // port latch for osc out
    input  wire logic       port_in_bit,       // port latch for osc in
    output logic            osc_select_hi,     // oscillator select bit 1
    output logic            osc_select_lo,     // oscillator select bit 0
    output logic            rc_run,            // internal rc enable
    output logic            rc_freq_select,    // 1 high rc frequency
    output logic            xtal_run,          // crystal amp enable
    output logic            ext_clk_sel,       // clock from osc in pin
    output logic            wdog_clk_select,   // 1 cpu clock to watchdog
    output logic            clk_filter_en,     // clock filter enable
    output logic [1:0]      brownout_level,    // runtime trip level
    output logic [8:0]      brownout_trip_level, // trip, centivolts
    output logic            detector_on,       // detector powered
    output logic            bo_cpu_reset,      // hold cpu in reset
    output logic            bo_irq,            // pulse on crossing
    output logic            osc_out_pin_o,     // osc out pin drive
    output logic            osc_out_pin_oe_n,  // low while driving
    output logic            osc_in_pin_o,      // osc in pin drive
    output logic            osc_in_pin_oe_n    // low while driving
);
    import csb_pkg::*;

    // decode the configuration brownout field to a trip level
    function automatic logic [8:0] trip_of(input logic [1:0] cfg_brownout_level);
        case (cfg_brownout_level)
            CFG_BROWNOUT_LEVEL_2V4: trip_of = TRIP_2V4;
            CFG_BROWNOUT_LEVEL_2V7: trip_of = TRIP_2V7;
            CFG_BROWNOUT_LEVEL_3V8: trip_of = TRIP_3V8;
            default:  trip_of = TRIP_4V5;
        endcase
    endfunction

    logic [7:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
    logic       loaded_q, loaded_d;
    logic [1:0] bov_q, bov_d;

    // latch config once after reset; later loads are ignored
    always_comb begin
        cfg0_d   = cfg0_q;
        cfg1_d   = cfg1_q;
        loaded_d = loaded_q;
        bov_d    = bov_q;
        if (cfg_load && !loaded_q) begin
            cfg0_d   = cfg_byte_zero;
            cfg1_d   = cfg_byte_one;
            loaded_d = 1'b1;
            bov_d    = ~cfg_byte_zero[CFG0_BOV_HI:CFG0_BOV_LO];
        end else if (brownout_level_we && loaded_q) begin
            bov_d = brownout_level_wr;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg0_q   <= CFG_RST;
            cfg1_q   <= CFG_RST;
            loaded_q <= 1'b0;
            bov_q    <= ~CFG_BROWNOUT_LEVEL_4V5; // matches the 4.5 V trip held in reset
        end else begin
            cfg0_q   <= cfg0_d;
            cfg1_q   <= cfg1_d;
            loaded_q <= loaded_d;
            bov_q    <= bov_d;
        end
    end

    logic [1:0] osc_sel;
    assign osc_sel = {cfg0_q[CFG0_OSC_HI], cfg0_q[CFG0_OSC_LO]};

    // clock output divider, runs regardless of idle
    logic [1:0] div_q, div_d;
    logic       ck_q, ck_d;
    logic       ck_allow;
    assign ck_allow = aux_clock_ctrl[ACK_CLKOUT_BIT]
                      && (osc_sel == OSC_INT_RC || osc_sel == OSC_EXT_CLK);

    always_comb begin
        div_d = div_q;
        ck_d  = ck_q;
        if (!ck_allow) begin
            div_d = 2'h0;
            ck_d  = 1'b0;
        end else if (div_q == 2'(CLKOUT_HALF - 1)) begin
            div_d = 2'h0;
            ck_d  = ~ck_q;
        end else begin
            div_d = div_q + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_q <= 2'h0;
            ck_q  <= 1'b0;
        end else begin
            div_q <= div_d;
            ck_q  <= ck_d;
        end
    end

    // brownout response machine
    csb_bo_type bo_q, bo_d;
    logic       irq_d, rst_d;
    csb_duty_if duty ();

    assign duty.run  = low_power_brownout && bo_q == BO_LOW;
    assign duty.tick = detector_rc_tick;

    csb_duty_seq u_duty (
        .mclk (mclk),
        .srst (srst),
        .duty (duty)
    );

    always_comb begin
        bo_d  = bo_q;
        irq_d = 1'b0;
        case (bo_q)
            BO_IDLE: bo_d = loaded_q ? BO_OK : BO_IDLE;
            BO_OK: begin
                if (vdd_below) begin
                    bo_d  = BO_LOW;
                    irq_d = !bo_reset_en;
                end
            end
            BO_LOW: begin
                if (!vdd_below && duty.sense) begin
                    bo_d  = BO_OK;
                    irq_d = !bo_reset_en;
                end
            end
            default: bo_d = BO_IDLE;
        endcase
        rst_d = bo_reset_en && bo_d == BO_LOW;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bo_q         <= BO_IDLE;
            bo_irq       <= 1'b0;
            bo_cpu_reset <= 1'b0;
        end else begin
            bo_q         <= bo_d;
            bo_irq       <= irq_d;
            bo_cpu_reset <= rst_d;
        end
    end

    // registered configuration and pin outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_select_hi       <= 1'b0;
            osc_select_lo       <= 1'b0;
            rc_run              <= 1'b0;
            rc_freq_select      <= 1'b0;
            xtal_run            <= 1'b0;
            ext_clk_sel         <= 1'b0;
            wdog_clk_select     <= 1'b0;
            clk_filter_en       <= 1'b0;
            brownout_level      <= ~CFG_BROWNOUT_LEVEL_4V5;
            brownout_trip_level <= TRIP_4V5;
            detector_on         <= 1'b1;
            osc_out_pin_o       <= 1'b1;
            osc_out_pin_oe_n    <= 1'b1;
            osc_in_pin_o        <= 1'b1;
            osc_in_pin_oe_n     <= 1'b1;
        end else begin
            osc_select_hi   <= osc_sel[1];
            osc_select_lo   <= osc_sel[0];
            rc_run          <= osc_sel == OSC_INT_RC;
            ext_clk_sel     <= osc_sel == OSC_EXT_CLK;
            xtal_run        <= osc_sel == OSC_CRYSTAL;
            rc_freq_select  <= cfg1_q[CFG1_RCF_BIT];
            wdog_clk_select <= cfg0_q[CFG0_WDOG_BIT];
            clk_filter_en   <= cfg0_q[CFG0_FILT_BIT];
            brownout_level  <= bov_q;
            brownout_trip_level <= trip_of(~bov_q);
            detector_on     <= duty.sense;
            osc_in_pin_o    <= port_in_bit;
            osc_in_pin_oe_n <= !(osc_sel == OSC_INT_RC && !port_in_bit);
            if (ck_allow) begin
                osc_out_pin_o    <= ck_d;
                osc_out_pin_oe_n <= 1'b0;
            end else if (osc_sel == OSC_INT_RC) begin
                osc_out_pin_o    <= port_out_bit;
                osc_out_pin_oe_n <= port_out_bit;
            end else begin
                osc_out_pin_o    <= 1'b1;
                osc_out_pin_oe_n <= 1'b1;
            end
        end
    end

    // configuration capture and brownout level
    chk_cfg_frozen: assert property (
        @(posedge mclk) disable iff (srst)
        loaded_q |=> $stable(cfg0_q) && $stable(cfg1_q))
        else $error("config changed after load");
    chk_bov_invert: assert property (
        @(posedge mclk) disable iff (srst)
        cfg_load && !loaded_q |=> bov_q == ~$past(cfg_byte_zero[6:5]))
        else $error("level not inverted config");
    chk_lvl_refused: assert property (
        @(posedge mclk) disable iff (srst)
        !loaded_q && !cfg_load |=> $stable(bov_q))
        else $error("level changed before load");
    chk_trip_map: assert property (
        @(posedge mclk) disable iff (srst)
        bov_q == 2'h0 |=> brownout_trip_level == TRIP_2V4)
        else $error("level 0 not lowest trip");
    chk_wdog_sel: assert property (
        @(posedge mclk) disable iff (srst)
        loaded_q |=> wdog_clk_select == $past(cfg0_q[7]))
        else $error("watchdog select wrong");
    chk_rc_freq: assert property (
        @(posedge mclk) disable iff (srst)
        loaded_q |=> rc_freq_select == $past(cfg1_q[5]))
        else $error("rc frequency select wrong");

    // oscillator selection and pins
    chk_rc_run: assert property (
        @(posedge mclk) disable iff (srst)
        osc_sel == OSC_INT_RC |=> rc_run && !xtal_run && !ext_clk_sel)
        else $error("rc mode not selected");
    chk_ext_sel: assert property (
        @(posedge mclk) disable iff (srst)
        osc_sel == OSC_EXT_CLK |=> ext_clk_sel && !rc_run && !xtal_run)
        else $error("external clock not selected");
    chk_rc_pins: assert property (
        @(posedge mclk) disable iff (srst)
        osc_sel == OSC_INT_RC && !ck_allow
        |=> osc_out_pin_oe_n == $past(port_out_bit)
            && osc_in_pin_oe_n == $past(port_in_bit))
        else $error("rc mode pins not port bits");
    chk_xtal_quiet: assert property (
        @(posedge mclk) disable iff (srst)
        osc_sel == OSC_CRYSTAL |=> osc_out_pin_oe_n)
        else $error("crystal mode drove osc out");
    chk_ext_float: assert property (
        @(posedge mclk) disable iff (srst)
        osc_sel == OSC_EXT_CLK && !ck_allow |=> osc_out_pin_oe_n)
        else $error("ext clock pin not floating");
    chk_clkout_drive: assert property (
        @(posedge mclk) disable iff (srst)
        ck_allow |=> !osc_out_pin_oe_n && osc_out_pin_o == ck_q)
        else $error("clock output not on pin");
    chk_clkout_rate: assert property (
        @(posedge mclk) disable iff (srst)
        ck_allow && $changed(ck_q) ##1 ck_allow ##1 ck_allow
        |-> $changed(ck_q))
        else $error("clock output not quarter rate");

    // brownout response
    chk_bo_reset: assert property (
        @(posedge mclk) disable iff (srst)
        bo_q == BO_OK && vdd_below && bo_reset_en |=> bo_cpu_reset)
        else $error("brownout reset missing");
    chk_bo_irq: assert property (
        @(posedge mclk) disable iff (srst)
        bo_q == BO_OK && vdd_below && !bo_reset_en
        |=> bo_irq ##1 (!bo_irq || bo_q == BO_OK))
        else $error("brownout irq not one pulse");
    chk_irq_rise: assert property (
        @(posedge mclk) disable iff (srst)
        bo_q == BO_LOW && !vdd_below && duty.sense && !bo_reset_en
        |=> bo_irq)
        else $error("recovery irq missing");
    chk_bo_recover: assert property (
        @(posedge mclk) disable iff (srst)
        bo_q == BO_LOW && !vdd_below && duty.sense |=> !bo_cpu_reset)
        else $error("cpu reset not released");
    chk_lp_idle: assert property (
        @(posedge mclk) disable iff (srst)
        !duty.run |=> duty.sense)
        else $error("detector off outside duty cycling");
endmodule
`default_nettype wire

// ===== dv/csb_clk_sink.sv
`timescale 1ns/1ps
`default_nettype none
// far-side device that locks onto the divided clock output
module csb_clk_sink (
    input  wire logic       mclk,    // system clock
    input  wire logic       pin,     // resolved level of osc out pin
    output logic [7:0]      period,  // cycles between last two rises
    output logic [7:0]      rises    // running count of rising edges
);
    logic       prev_q = 1'b1;
    logic [7:0] cnt_q  = 8'h00;

    initial period = 8'h00;
    initial rises  = 8'h00;

    // measure the rise-to-rise spacing of the pin, as a synchroniser would
    always @(posedge mclk) begin
        prev_q <= pin;
        if (pin && !prev_q) begin
            period <= cnt_q;
            cnt_q  <= 8'h01;
            rises  <= rises + 8'h01;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== dv/csb_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module csb_top_tb_top;
    import csb_pkg::*;
    logic       mclk = 1'b0, srst = 1'b1, cfg_load = 1'b0;
    logic [7:0] cfg_byte_zero = 8'h00, cfg_byte_one = 8'h00;
    logic [7:0] aux_clock_ctrl = 8'h00;
    logic [1:0] brownout_level_wr = 2'h0;
    logic       brownout_level_we = 1'b0, bo_reset_en = 1'b0;
    logic       low_power_brownout = 1'b0, detector_rc_tick = 1'b0;
    logic       vdd_below = 1'b0, port_out_bit = 1'b1, port_in_bit = 1'b1;
    logic       osc_select_hi, osc_select_lo, rc_run, rc_freq_select;
    logic       xtal_run, ext_clk_sel, wdog_clk_select, clk_filter_en;
    logic [1:0] brownout_level;
    logic [8:0] brownout_trip_level;
    logic       detector_on, bo_cpu_reset, bo_irq;
    logic       osc_out_pin_o, osc_out_pin_oe_n, osc_in_pin_o, osc_in_pin_oe_n;
    logic [7:0] period, rises;
    int         bad_count = 0, cmp_count = 0;
    // pins carry pull-ups: released pins read high
    wire        out_lvl = osc_out_pin_oe_n ? 1'b1 : osc_out_pin_o;
    wire        in_lvl  = osc_in_pin_oe_n ? 1'b1 : osc_in_pin_o;

    always #5 mclk = ~mclk;

    csb_top dut (.mclk(mclk), .srst(srst), .cfg_load(cfg_load),
        .cfg_byte_zero(cfg_byte_zero), .cfg_byte_one(cfg_byte_one),
        .aux_clock_ctrl(aux_clock_ctrl), .brownout_level_wr(brownout_level_wr),
        .brownout_level_we(brownout_level_we), .bo_reset_en(bo_reset_en),
        .low_power_brownout(low_power_brownout),
        .detector_rc_tick(detector_rc_tick), .vdd_below(vdd_below),
        .port_out_bit(port_out_bit), .port_in_bit(port_in_bit),
        .osc_select_hi(osc_select_hi), .osc_select_lo(osc_select_lo),
        .rc_run(rc_run), .rc_freq_select(rc_freq_select),
        .xtal_run(xtal_run), .ext_clk_sel(ext_clk_sel),
        .wdog_clk_select(wdog_clk_select), .clk_filter_en(clk_filter_en),
        .brownout_level(brownout_level),
        .brownout_trip_level(brownout_trip_level), .detector_on(detector_on),
        .bo_cpu_reset(bo_cpu_reset), .bo_irq(bo_irq),
        .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_n(osc_out_pin_oe_n),
        .osc_in_pin_o(osc_in_pin_o), .osc_in_pin_oe_n(osc_in_pin_oe_n));

    csb_clk_sink sink (.mclk(mclk), .pin(out_lvl), .period(period),
        .rises(rises));

    // print the counts and the verdict, then stop
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic fail_wait(input string n);
        bad_count++;
        $display("MISMATCH %s exp event got timeout", n);
        conclude();
    endtask

    // ten-cycle reset with the clock-out, brownout and detector inputs back at rest
    task automatic do_reset();
        @(posedge mclk);
        srst <= 1'b1;
        aux_clock_ctrl <= 8'h00;
        vdd_below <= 1'b0;
        bo_reset_en <= 1'b0;
        low_power_brownout <= 1'b0;
        detector_rc_tick <= 1'b0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        #1;
    endtask

    task automatic load(input logic [7:0] c0, input logic [7:0] c1);
        @(posedge mclk);
        cfg_byte_zero <= c0;
        cfg_byte_one <= c1;
        cfg_load <= 1'b1;
        @(posedge mclk);
        cfg_load <= 1'b0;
        tick_n(3);
    endtask

    function automatic logic [8:0] trip_of(input logic [1:0] code);
        case (code)
            2'h3: trip_of = 9'h0f0;
            2'h2: trip_of = 9'h10e;
            2'h1: trip_of = 9'h17c;
            default: trip_of = 9'h1c2;
        endcase
    endfunction

    // every brownout code, plus the values held before any load
    task automatic t_bov();
        logic [1:0] code;
        `CHK("trip_rst", 9'h1c2, brownout_trip_level)
        `CHK("out_oe_rst", 1'b1, osc_out_pin_oe_n)
        for (int k = 0; k < 4; k++) begin
            code = 2'(k);
            do_reset();
            load({1'b0, code, 5'h01}, 8'h00);
            `CHK("bo_level", ~code, brownout_level)
            `CHK("trip", trip_of(code), brownout_trip_level)
        end
    endtask

    // rc mode: selects, port pins, refused reload, clock output on and off
    task automatic t_rc();
        logic [7:0] r0;
        do_reset();
        load(8'h25, 8'h20);
        `CHK("sel", 2'h1, {osc_select_hi, osc_select_lo})
        `CHK("rc_run", 1'b1, rc_run)
        `CHK("rc_freq", 1'b1, rc_freq_select)
        `CHK("wdog", 1'b0, wdog_clk_select)
        `CHK("filter", 1'b1, clk_filter_en)
        load(8'h83, 8'h00);
        `CHK("sel_again", 2'h1, {osc_select_hi, osc_select_lo})
        `CHK("rc_freq_again", 1'b1, rc_freq_select)
        @(posedge mclk);
        port_out_bit <= 1'b0;
        port_in_bit <= 1'b0;
        tick_n(3);
        `CHK("pins_low", 2'h0, {out_lvl, in_lvl})
        @(posedge mclk);
        port_out_bit <= 1'b1;
        port_in_bit <= 1'b1;
        tick_n(3);
        `CHK("pins_high", 2'h3, {out_lvl, in_lvl})
        @(posedge mclk);
        aux_clock_ctrl <= 8'h80;
        tick_n(40);
        r0 = rises;
        `CHK("clk_period", 8'h04, period)
        tick_n(40);
        `CHK("clk_rises", 8'h0a, 8'(rises - r0))
        // output no longer needed: software turns it off first
        @(posedge mclk);
        aux_clock_ctrl <= 8'h00;
        tick_n(4);
        r0 = rises;
        tick_n(20);
        `CHK("clk_stopped", r0, rises)
    endtask

    task automatic t_ext();
        logic [7:0] r0;
        do_reset();
        load(8'h83, 8'h00);
        `CHK("ext_sel", 2'h3, {osc_select_hi, osc_select_lo})
        `CHK("ext_clk", 1'b1, ext_clk_sel)
        `CHK("wdog", 1'b1, wdog_clk_select)
        `CHK("rc_freq", 1'b0, rc_freq_select)
        `CHK("out_float", 1'b1, osc_out_pin_oe_n)
        @(posedge mclk);
        aux_clock_ctrl <= 8'h80;
        tick_n(40);
        r0 = rises;
        tick_n(40);
        `CHK("clk_period", 8'h04, period)
        `CHK("ext_rises", 8'h0a, 8'(rises - r0))
    endtask

    // level writes: refused before the load, taken after it
    task automatic t_lvl();
        do_reset();
        @(posedge mclk);
        brownout_level_wr <= 2'h2;
        brownout_level_we <= 1'b1;
        @(posedge mclk);
        brownout_level_we <= 1'b0;
        tick_n(2);
        `CHK("lvl_refused", ~CFG_BROWNOUT_LEVEL_4V5, brownout_level)
        `CHK("trip_refused", TRIP_4V5, brownout_trip_level)
        load(8'h61, 8'h00);
        `CHK("lvl_load", 2'h0, brownout_level)
        `CHK("trip_load", TRIP_2V4, brownout_trip_level)
        @(posedge mclk);
        brownout_level_wr <= 2'h1;
        brownout_level_we <= 1'b1;
        @(posedge mclk);
        brownout_level_we <= 1'b0;
        tick_n(2);
        `CHK("lvl_write", 2'h1, brownout_level)
        `CHK("trip_write", TRIP_2V7, brownout_trip_level)
    endtask

    // crystal with the enable already set: the pin must stay quiet
    task automatic t_xtal();
        logic [7:0] r0;
        do_reset();
        @(posedge mclk);
        aux_clock_ctrl <= 8'h80;
        load(8'h00, 8'h20);
        r0 = rises;
        `CHK("xtal_run", 1'b1, xtal_run)
        tick_n(20);
        `CHK("xtal_rises", r0, rises)
        `CHK("xtal_oe", 1'b1, osc_out_pin_oe_n)
    endtask

    // interrupt on the fall and on the recovery, then reset response
    task automatic t_bo();
        int i;
        do_reset();
        load(8'h01, 8'h00);
        @(posedge mclk);
        vdd_below <= 1'b1;
        for (i = 0; i < 8 && bo_irq !== 1'b1; i++) tick_n(1);
        if (i == 8) fail_wait("irq_fall");
        tick_n(1);
        `CHK("irq_pulse", 2'h0, {bo_irq, bo_cpu_reset})
        @(posedge mclk);
        vdd_below <= 1'b0;
        for (i = 0; i < 8 && bo_irq !== 1'b1; i++) tick_n(1);
        `CHK("irq_rise", 1'b1, bo_irq)
        do_reset();
        load(8'h01, 8'h00);
        @(posedge mclk);
        bo_reset_en <= 1'b1;
        vdd_below <= 1'b1;
        tick_n(24);
        `CHK("cpu_reset_held", 1'b1, bo_cpu_reset)
        @(posedge mclk);
        vdd_below <= 1'b0;
        for (i = 0; i < 8 && bo_cpu_reset !== 1'b0; i++) tick_n(1);
        `CHK("cpu_reset_freed", 1'b0, bo_cpu_reset)
    endtask

    // duty cycling with a detector tick on every cycle
    task automatic t_lp();
        int i;
        int n;
        do_reset();
        load(8'h01, 8'h00);
        @(posedge mclk);
        bo_reset_en <= 1'b1;
        low_power_brownout <= 1'b1;
        detector_rc_tick <= 1'b1;
        vdd_below <= 1'b1;
        for (i = 0; i < 200 && detector_on !== 1'b0; i++) tick_n(1);
        if (i == 200) fail_wait("detector_off");
        for (n = 0; n < 2000 && detector_on === 1'b0; n++) tick_n(1);
        `CHK("off_run", 960, n)
        for (n = 0; n < 200 && detector_on === 1'b1; n++) tick_n(1);
        `CHK("on_run", 64, n)
    endtask

    initial begin
        do_reset();
        t_bov();
        t_lvl();
        t_rc();
        t_ext();
        t_xtal();
        t_bo();
        t_lp();
        conclude();
    end
endmodule
`undef CHK
`default_nettype wire
